// [hw/lpmc_pkg.sv]
// Package for the low-power mode controller: codes, widths, structs
package lpmc_pkg;
  // ==========================================================
  // Mode select codes and field widths
  localparam logic [1:0] LPMC_MODE_IDLE    = 2'h0;
  localparam logic [1:0] LPMC_MODE_STANDBY = 2'h1;
  localparam int         LPMC_QUAL_W       = 6;
  localparam int         LPMC_CNT_W        = 7;
  localparam logic [6:0] LPMC_QUAL_BASE    = 7'h02;  // Code 0 gives two cycles
  localparam logic [6:0] LPMC_CNT_ZERO     = 7'h00;
  localparam logic [6:0] LPMC_CNT_ONE      = 7'h01;
  // Cycles of oscillator clock allowed for power-up and PLL relock
  localparam int         LPMC_OSC_UP_CYC   = 16;
  localparam int         LPMC_LOCK_CYC     = 16;
  localparam int         LPMC_TMR_W        = 8;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LPMC_RUN, LPMC_IDLE, LPMC_STBY, LPMC_HALT, LPMC_OSC_UP, LPMC_RELOCK
  } lpmc_state_e;

  // Software controls
  typedef struct packed {
    logic [1:0] power_mode_select;
    logic [5:0] standby_qualify_count;
    logic       watchdog_wake_permit;
  } lpmc_ctrl_s;

  // Clock gate outputs
  typedef struct packed {
    logic cpu_clock_input_en;
    logic system_clock_out_en;
    logic osc_en;
    logic pll_en;
  } lpmc_gate_s;
endpackage : lpmc_pkg

// [hw/lpmc_qual.sv]
// Wake pin qualifier: counts consecutive low samples
`timescale 1ns/10ps
module lpmc_qual #(
  parameter int QW = 6
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          run,
  input  wire logic [QW-1:0] qual_code,
  input  wire logic          pin_n,
  output logic               done
);
  import lpmc_pkg::*;

  initial begin
    if (QW != LPMC_QUAL_W) $error("lpmc_qual: width must match package");
  end

  typedef struct packed {
    logic [LPMC_CNT_W-1:0] cnt;
    logic                  done;
  } lpmc_qst_s;

  lpmc_qst_s st;
  lpmc_qst_s next_st;
  logic [LPMC_CNT_W-1:0] target;

  // ==========================================================
  // Count of low samples; a high sample restarts the count
  assign target = LPMC_QUAL_BASE + {1'b0, qual_code};

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (!run || pin_n) begin
      next_st.cnt = LPMC_CNT_ZERO;
    end else if (st.cnt + LPMC_CNT_ONE >= target) begin
      next_st.done = 1'b1;
      next_st.cnt  = LPMC_CNT_ZERO;
    end else begin
      next_st.cnt = st.cnt + LPMC_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

  // Done only right after a low pin sample taken while running
  property p_qual_len;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(done) |-> $past(!pin_n && run);
  endproperty
  a_qual_len: assert property (p_qual_len) else $error("qualified without low pin");

  property p_qual_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      (run && pin_n) |=> (st.cnt == LPMC_CNT_ZERO && !done);
  endproperty
  a_qual_restart: assert property (p_qual_restart) else $error("count kept on high");
endmodule : lpmc_qual

// [hw/lpmc_top.sv]
// Low-power mode controller: idle, standby and halt sequencing
//
// Contract
// - Idle does nothing itself; any enabled interrupt or NMI leaves it.
// - System clock output keeps running in idle.
// - Mode code 01 plus idle instruction enters standby.
// - Standby gates CPU clock; oscillator, PLL, watchdog keep running.
// - Standby exits on wake pin, external reset, or permitted watchdog interrupt.
// - Standby wake pin must stay low for the qualify count.
// - A high sample during qualification restarts the count.
// - Qualification done re-enables CPU clock and latches wake interrupt.
// - Wake interrupt shared by watchdog and low-power wake.
// - Mode code 1x plus idle instruction enters halt.
// - Halt stops all four clock gates, PLL and oscillator included.
// - Halt exits only on wake pin or external reset.
// - In halt a falling wake pin starts oscillator power-up unqualified.
// - Pin high releases PLL; after lock CPU clock returns.
// - Debug port keeps working with CPU clock gated.
// - Qualify time is field value plus two oscillator cycles.
// - Watchdog wake permit allows standby wake only when set.
// - Mode select acts only when the idle instruction executes.
`timescale 1ns/10ps
module lpmc_top #(
  parameter int OSC_UP_CYC = lpmc_pkg::LPMC_OSC_UP_CYC,
  parameter int LOCK_CYC   = lpmc_pkg::LPMC_LOCK_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire lpmc_pkg::lpmc_ctrl_s ctrl,
  input  wire logic                idle_instr,
  input  wire logic                any_enabled_int,
  input  wire logic                nmi,
  input  wire logic                wake_pin_n,
  input  wire logic                watchdog_int,
  input  wire logic                missing_clock_flag,
  input  wire logic                debug_req,
  output lpmc_pkg::lpmc_gate_s     gates,
  output logic                     wake_interrupt,
  output logic                     cpu_resume,
  output logic                     debug_clock_en,
  output logic                     low_power_active
);
  import lpmc_pkg::*;

  initial begin
    if (OSC_UP_CYC < 1 || OSC_UP_CYC >= (1 << LPMC_TMR_W)) $error("OSC_UP_CYC out of range");
    // Relock must last two edges at least, so the CPU clock never reopens on lock entry
    if (LOCK_CYC < 2 || LOCK_CYC >= (1 << LPMC_TMR_W)) $error("LOCK_CYC out of range");
  end

  localparam logic [LPMC_TMR_W-1:0] OSC_T  = LPMC_TMR_W'(OSC_UP_CYC - 1);
  localparam logic [LPMC_TMR_W-1:0] LOCK_T = LPMC_TMR_W'(LOCK_CYC - 1);
  localparam logic [LPMC_TMR_W-1:0] TMR_0  = '0;
  localparam logic [LPMC_TMR_W-1:0] TMR_1  = LPMC_TMR_W'(1);

  typedef struct packed {
    lpmc_state_e           state;
    logic [LPMC_TMR_W-1:0] tmr;
    logic                  wake_int;
    logic                  resume;
    lpmc_gate_s            gates;
  } lpmc_st_s;

  lpmc_st_s st;
  lpmc_st_s next_st;
  logic     qual_done;

  // Mode decode used only by entry from run; status does not use it
  function automatic lpmc_state_e mode_target(input logic [1:0] sel);
    if (sel[1])                        return LPMC_HALT;
    else if (sel == LPMC_MODE_STANDBY) return LPMC_STBY;
    else                               return LPMC_IDLE;
  endfunction : mode_target

  // ==========================================================
  // Standby wake qualifier
  lpmc_qual #(.QW(LPMC_QUAL_W)) u_qual (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .run       (st.state == LPMC_STBY),
    .qual_code (ctrl.standby_qualify_count),
    .pin_n     (wake_pin_n),
    .done      (qual_done)
  );

  // ==========================================================
  // Mode sequencer; mode select is only read on the idle instruction
  always_comb begin
    next_st          = st;
    next_st.wake_int = 1'b0;
    next_st.resume   = 1'b0;
    unique case (st.state)
      LPMC_RUN: begin
        if (idle_instr) begin
          next_st.state = mode_target(ctrl.power_mode_select);
          if (mode_target(ctrl.power_mode_select) != LPMC_IDLE) begin
            next_st.gates.cpu_clock_input_en  = 1'b0;
            next_st.gates.system_clock_out_en = 1'b0;
          end
          if (mode_target(ctrl.power_mode_select) == LPMC_HALT) begin
            next_st.gates.osc_en = 1'b0;
            next_st.gates.pll_en = 1'b0;
          end
        end
      end
      LPMC_IDLE: begin
        // Nothing gated here; the clocks keep running
        if (any_enabled_int || nmi) begin
          next_st.state  = LPMC_RUN;
          next_st.resume = 1'b1;
        end
      end
      LPMC_STBY: begin
        if (qual_done || (watchdog_int && ctrl.watchdog_wake_permit)) begin
          next_st.state                     = LPMC_RUN;
          next_st.gates.cpu_clock_input_en  = 1'b1;
          next_st.gates.system_clock_out_en = 1'b1;
          next_st.wake_int                  = 1'b1;
          next_st.resume                    = 1'b1;
        end
      end
      LPMC_HALT: begin
        // Pin taken without qualification; watchdog is dead here
        if (!wake_pin_n) begin
          next_st.state        = LPMC_OSC_UP;
          next_st.gates.osc_en = 1'b1;
          next_st.tmr          = OSC_T;
        end
      end
      LPMC_OSC_UP: begin
        // Pin not looked at till the oscillator is up; then wait for it to go high
        if (st.tmr != TMR_0) begin
          next_st.tmr = st.tmr - TMR_1;
        end else if (wake_pin_n) begin
          next_st.state        = LPMC_RELOCK;
          next_st.gates.pll_en = 1'b1;
          next_st.tmr          = LOCK_T;
        end
      end
      LPMC_RELOCK: begin
        if (st.tmr != TMR_0) begin
          next_st.tmr = st.tmr - TMR_1;
        end else begin
          next_st.state                     = LPMC_RUN;
          next_st.gates.cpu_clock_input_en  = 1'b1;
          next_st.gates.system_clock_out_en = 1'b1;
          next_st.wake_int                  = 1'b1;
          next_st.resume                    = 1'b1;
        end
      end
      default: begin
        next_st.state = LPMC_RUN;
      end
    endcase
  end

  // External reset always wins and reopens every clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.state <= LPMC_RUN;
      st.gates <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign gates            = st.gates;
  assign wake_interrupt   = st.wake_int;
  assign cpu_resume       = st.resume;
  assign debug_clock_en   = debug_req | st.gates.osc_en;
  assign low_power_active = (st.state != LPMC_RUN);
  // Halt with missing clock flag set is software's fault; no guard here
  logic unused_mclk;
  assign unused_mclk = missing_clock_flag;

  // ==========================================================
  // Checks
  property p_idle_clk;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_IDLE) |-> gates.system_clock_out_en;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock stopped in idle");

  property p_stby_gate;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_STBY) |-> (!gates.cpu_clock_input_en && gates.osc_en && gates.pll_en);
  endproperty
  a_stby_gate: assert property (p_stby_gate) else $error("bad gating in standby");

  property p_enter_stby;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_RUN && idle_instr && ctrl.power_mode_select == LPMC_MODE_STANDBY)
        |=> (st.state == LPMC_STBY);
  endproperty
  a_enter_stby: assert property (p_enter_stby) else $error("standby not entered");

  property p_enter_halt;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_RUN && idle_instr && ctrl.power_mode_select[1])
        |=> (st.state == LPMC_HALT && !gates.osc_en && !gates.pll_en);
  endproperty
  a_enter_halt: assert property (p_enter_halt) else $error("halt not entered");

  property p_halt_exit;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_HALT && wake_pin_n) |=> (st.state == LPMC_HALT);
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt left without pin");

  property p_halt_wake;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_HALT && !wake_pin_n) |=> (st.state == LPMC_OSC_UP && gates.osc_en);
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("oscillator not started");

  property p_stby_wake;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_STBY && qual_done) |=> (wake_interrupt && gates.cpu_clock_input_en);
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("no wake after qualify");

  property p_wd_permit;
    @(posedge sys_clk) disable iff (!rst_n)
      (st.state == LPMC_STBY && !qual_done && !ctrl.watchdog_wake_permit) |=>
        (st.state == LPMC_STBY);
  endproperty
  a_wd_permit: assert property (p_wd_permit) else $error("unpermitted standby exit");

  property p_relock;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(st.state == LPMC_RELOCK) |-> !gates.cpu_clock_input_en [*2];
  endproperty
  a_relock: assert property (p_relock) else $error("clock restored before lock");
endmodule : lpmc_top

// [tb/lpmc_partner.sv]
// Far-side model: wake pin driver and wake interrupt latch
`timescale 1ns/10ps
module lpmc_partner (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [7:0] low_len,
  input  wire logic [7:0] gap_at,
  input  wire logic       wake_interrupt,
  output logic            wake_pin_n,
  output int              wake_count
);
  int left;

  // ==========================================================
  // Pin starts released high, nothing latched
  initial begin
    wake_pin_n = 1'b1;
    wake_count = 0;
    left       = 0;
  end

  // Hold length loaded on the edge so it never races the bench
  always @(posedge sys_clk) begin
    if (go === 1'b1) begin
      left = int'(low_len);
    end
  end

  // Held low the whole length; a gap slot gives one high sample
  always @(negedge sys_clk) begin
    wake_pin_n <= !(left > 0 && left != int'(gap_at));
    if (left > 0) begin
      left = left - 1;
    end
  end

  // Shared wake line latch of the interrupt expander
  always @(posedge sys_clk) begin
    if (wake_interrupt === 1'b1) begin
      wake_count <= wake_count + 1;
    end
  end
endmodule : lpmc_partner

// [tb/lpmc_top_tb_top.sv]
// Self-checking testbench for the low-power mode controller
`timescale 1ns/10ps
`define LPMC_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module lpmc_top_tb_top;
  import lpmc_pkg::*;
  localparam int OSC_UP = 4;
  localparam int LOCK   = 3;
  logic       sys_clk, rst_n, idle_instr, any_enabled_int, nmi, watchdog_int, debug_req;
  logic       go, wake_pin_n, wake_interrupt, cpu_resume, debug_clock_en, low_power_active;
  logic [7:0] low_len, gap_at;
  lpmc_ctrl_s ctrl;
  lpmc_gate_s gates;
  int         wake_count, n_mismatch, comparisons, seed, cyc, exp_wakes, qn;
  int         codes[$];

  lpmc_top #(.OSC_UP_CYC(OSC_UP), .LOCK_CYC(LOCK)) lpmc_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .ctrl(ctrl), .idle_instr(idle_instr),
    .any_enabled_int(any_enabled_int), .nmi(nmi), .wake_pin_n(wake_pin_n),
    .watchdog_int(watchdog_int), .missing_clock_flag(1'b0),
    .debug_req(debug_req), .gates(gates), .wake_interrupt(wake_interrupt),
    .cpu_resume(cpu_resume), .debug_clock_en(debug_clock_en),
    .low_power_active(low_power_active));

  lpmc_partner lpmc_partner_inst (
    .sys_clk(sys_clk), .go(go), .low_len(low_len), .gap_at(gap_at),
    .wake_interrupt(wake_interrupt), .wake_pin_n(wake_pin_n), .wake_count(wake_count));

  // ==========================================================
  // 20 MHz oscillator clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Pulse the idle instruction with a mode code, then let it settle
  task automatic enter(input logic [1:0] mode);
    @(negedge sys_clk);
    ctrl.power_mode_select = mode;
    idle_instr = 1'b1;
    @(negedge sys_clk);
    idle_instr = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : enter

  // Ask the far side to pull the wake pin low; low from the last negedge
  task automatic pin(input int len, input int gap);
    @(negedge sys_clk);
    low_len = len[7:0];
    gap_at = gap[7:0];
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
  endtask : pin

  // Bounded wait for a wake or resume pulse; a hang ends the run
  task automatic wait_out(input bit resume, input int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(negedge sys_clk);
      if ((resume ? cpu_resume : wake_interrupt) === 1'b1) return;
    end
    n_mismatch++;
    test_done();
  endtask : wait_out

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h1611;
    {idle_instr, any_enabled_int, nmi, watchdog_int, debug_req, go} = 6'h00;
    ctrl = '0;
    low_len = 8'h00;
    gap_at = 8'hFF;
    {n_mismatch, comparisons, exp_wakes} = 0;
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    `LPMC_CHK(gates, 4'hF)
    // Mode field alone must not change anything
    ctrl.power_mode_select = LPMC_MODE_STANDBY;
    repeat (3) @(negedge sys_clk);
    `LPMC_CHK(low_power_active, 1'b0)
    // Idle left by an NMI, then by an enabled interrupt
    for (int s = 0; s < 2; s++) begin
      enter(LPMC_MODE_IDLE);
      `LPMC_CHK(gates, 4'hF)
      `LPMC_CHK(low_power_active, 1'b1)
      nmi = (s == 0);
      any_enabled_int = (s == 1);
      wait_out(1, 4, cyc);
      {nmi, any_enabled_int} = 2'h0;
      `LPMC_CHK(wake_count, exp_wakes)
    end
    // Standby qualification at both ends of the field, code 1 and one random code
    codes = '{0, 1, 0, 63};
    codes[2] = int'($unsigned($random(seed)) % 64);
    foreach (codes[i]) begin
      ctrl.standby_qualify_count = codes[i][5:0];
      qn = codes[i] + 2;
      enter(LPMC_MODE_STANDBY);
      `LPMC_CHK(gates, 4'h3)
      // Odd runs put one high sample after qn-1 lows, so counting restarts
      pin(2 * qn + 4, (i % 2) ? qn + 5 : -1);
      wait_out(0, 200, cyc);
      exp_wakes++;
      // Done registers on the last low sample, exit one edge later
      `LPMC_CHK(cyc, (i % 2) ? 2 * qn + 1 : qn + 1)
      `LPMC_CHK(gates, 4'hF)
      `LPMC_CHK(cpu_resume, 1'b1)
      repeat (qn + 4) @(negedge sys_clk);
    end
    // Watchdog wakes standby only once permitted
    enter(LPMC_MODE_STANDBY);
    watchdog_int = 1'b1;
    repeat (10) @(negedge sys_clk);
    `LPMC_CHK(gates, 4'h3)
    ctrl.watchdog_wake_permit = 1'b1;
    wait_out(0, 6, cyc);
    exp_wakes++;
    watchdog_int = 1'b0;
    `LPMC_CHK(gates, 4'hF)
    // Halt with both codes; watchdog must not wake it
    for (int m = 2; m < 4; m++) begin
      debug_req = m[0];
      enter(m[1:0]);
      `LPMC_CHK(gates, 4'h0)
      `LPMC_CHK(debug_clock_en, m[0])
      watchdog_int = 1'b1;
      repeat (4) @(negedge sys_clk);
      watchdog_int = 1'b0;
      `LPMC_CHK(gates, 4'h0)
      pin(OSC_UP + 3, -1);
      repeat (2) @(negedge sys_clk);
      `LPMC_CHK(gates.osc_en, 1'b1)
      `LPMC_CHK(gates.pll_en, 1'b0)
      wait_out(0, OSC_UP + LOCK + 10, cyc);
      exp_wakes++;
      `LPMC_CHK(gates, 4'hF)
    end
    // External reset leaves standby at once
    enter(LPMC_MODE_STANDBY);
    rst_n = 1'b0;
    @(negedge sys_clk);
    `LPMC_CHK(gates, 4'hF)
    rst_n = 1'b1;
    @(negedge sys_clk);
    `LPMC_CHK(wake_count, exp_wakes)
    test_done();
  end
endmodule : lpmc_top_tb_top
